/* File: hdl/sad_pkg.sv */
// shared constants, register map and types of the scope acquisition block
package sad_pkg;

	// sample path geometry
	localparam int ADC_W = 8; // bits per sample
	localparam int MEM_DEPTH = 16384; // samples per channel
	localparam int MEM_AW = 14; // ring address width
	localparam int CNT_W = 15; // sample counts up to MEM_DEPTH
	localparam int DECIM_W = 16; // decimation factor width
	localparam int OFS_W = 12; // offset dac code width
	localparam int RANGE_W = 4; // vertical range code width
	localparam int RANGE_COUNT = 10; // selectable vertical ranges

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DECIM = 8'h08;
	localparam logic [7:0] REG_PRE = 8'h0C;
	localparam logic [7:0] REG_POST = 8'h10;
	localparam logic [7:0] REG_LEN = 8'h14;
	localparam logic [7:0] REG_RANGE = 8'h18;
	localparam logic [7:0] REG_OFFSET = 8'h1C;
	localparam logic [7:0] REG_TLEVEL = 8'h20;
	localparam logic [7:0] REG_RDIDX = 8'h24;
	localparam logic [7:0] REG_RDDATA = 8'h28;

	// control register fields
	localparam int CTRL_START = 0; // write 1: begin acquisition
	localparam int CTRL_ABORT = 1; // write 1: stop at once
	localparam int CTRL_TSRC = 2; // 0 digital pin, 1 analog level
	localparam int CTRL_FILT = 3; // noise filter in
	localparam int CTRL_TCH = 4; // analog trigger channel

	// status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_TRIG = 1;
	localparam int STAT_DONE = 2;
	localparam int STAT_ERR = 3;

	// offset register: channel 1 code position
	localparam int OFS_CH1_LSB = 16;

	// reset values
	localparam logic [DECIM_W-1:0] DECIM_RST = 16'h0001;
	localparam logic [CNT_W-1:0] PRE_RST = 15'h0000;
	localparam logic [CNT_W-1:0] POST_RST = 15'h4000;
	localparam logic [CNT_W-1:0] LEN_RST = 15'h4000;
	localparam logic [RANGE_W-1:0] RANGE_RST = 4'h9;
	localparam logic [OFS_W-1:0] OFS_RST = 12'h800;
	localparam logic [ADC_W-1:0] TLEVEL_RST = 8'h80;

	// read wait states
	localparam logic [1:0] WAIT_REG = 2'h1;
	localparam logic [1:0] WAIT_MEM = 2'h2;

	// one sample pair, both channels
	typedef struct packed {
		logic [ADC_W-1:0] ch1;
		logic [ADC_W-1:0] ch0;
	} sad_sample_t;

	// acquisition path settings
	typedef struct packed {
		logic trig_ch;
		logic filter_en;
		logic trig_src;
	} sad_ctrl_t;

	// acquisition sequence
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_ARMED,
		ST_POST,
		ST_DONE
	} sad_state_t;

endpackage

/* File: hdl/sad_acq_mem.sv */
// dual-port acquisition ring memory, registered read
`timescale 1ns/1ps
module sad_acq_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16384,
	parameter int AW = 14
) (
	input wire logic clk_i,
	input wire logic wr_en_i,
	input wire logic [AW-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic [AW-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);

	// ring must fill its whole address space, refused at elaboration
	if (DEPTH != (1 << AW) || WIDTH < 1) begin : g_bad_depth
		$error("sad_acq_mem: DEPTH must equal 2**AW");
	end

	logic [WIDTH-1:0] mem_q [DEPTH]; // sample storage

	// write port
	always_ff @(posedge clk_i) begin
		if (wr_en_i)
			mem_q[wr_addr_i] <= wr_data_i;
	end

	// read port, one cycle latency
	always_ff @(posedge clk_i) begin
		rd_data_o <= mem_q[rd_addr_i];
	end

endmodule

/* File: hdl/sad_top.sv */
// scope acquisition: decimator, trigger, ring memory and register slave
`timescale 1ns/1ps
module sad_top #(
	parameter int DEPTH = sad_pkg::MEM_DEPTH,
	parameter int AW = sad_pkg::MEM_AW
) (
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic HWRITE_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic ADC_VALID_I,
	input wire logic [sad_pkg::ADC_W-1:0] ADC_CH0_I,
	input wire logic [sad_pkg::ADC_W-1:0] ADC_CH1_I,
	input wire logic TRIG_I,
	output logic [sad_pkg::RANGE_W-1:0] RANGE_SEL_O,
	output logic FILTER_EN_O,
	output logic [sad_pkg::OFS_W-1:0] OFFSET_CH0_O,
	output logic [sad_pkg::OFS_W-1:0] OFFSET_CH1_O,
	output logic ACQ_BUSY_O,
	output logic ACQ_DONE_O
);

	// ring must be a power of two no larger than the counters reach
	if (DEPTH != (1 << AW) || DEPTH > sad_pkg::MEM_DEPTH) begin : g_bad_depth
		$error("sad_top: DEPTH must be 2**AW and at most 16384");
	end

	localparam int CW = sad_pkg::CNT_W;
	localparam logic [CW:0] DEPTH_C = (CW+1)'(DEPTH); // split limit

	// ring offset arithmetic, wraps at DEPTH
	function automatic logic [AW-1:0] ring_add(input logic [AW-1:0] base,
		input logic [CW:0] off);
		logic [CW:0] sum;
		sum = (CW+1)'(base) + off;
		return sum[AW-1:0];
	endfunction

	// bus side state
	logic [7:0] addr_q; // data-phase register offset
	logic wr_pend_q; // write data phase open
	logic [1:0] wait_q; // read wait states left
	logic [31:0] hrdata_q;
	logic hready_q;
	logic addr_phase; // transfer accepted this cycle
	logic [31:0] rd_mux; // register read value

	// configuration
	sad_pkg::sad_ctrl_t ctrl_q;
	logic [sad_pkg::DECIM_W-1:0] decim_q;
	logic [CW-1:0] pre_q;
	logic [CW-1:0] post_q;
	logic [CW-1:0] len_q;
	logic [sad_pkg::RANGE_W-1:0] range_q;
	logic [sad_pkg::OFS_W-1:0] ofs0_q;
	logic [sad_pkg::OFS_W-1:0] ofs1_q;
	logic [sad_pkg::ADC_W-1:0] tlevel_q;

	// acquisition state
	sad_pkg::sad_state_t state_q;
	logic [sad_pkg::DECIM_W-1:0] dec_cnt_q; // decimation phase
	logic [AW-1:0] wr_ptr_q; // next ring slot
	logic [CW-1:0] stored_q; // pretrigger samples held
	logic [CW-1:0] post_cnt_q; // posttrigger samples held
	logic [AW-1:0] base_q; // oldest sample of the record
	logic trig_seen_q;
	logic err_q; // last start refused
	logic busy_q;
	logic done_q;
	logic [CW-1:0] rd_idx_q; // host read index
	logic running; // states that store samples
	logic keep; // decimator passes this sample
	logic start_cmd;
	logic abort_cmd;
	logic split_ok; // pre plus post fits
	logic [CW:0] total; // record length
	logic trig_evt;

	// trigger pin synchroniser and filter
	logic trig_s1_q;
	logic trig_s2_q;
	logic trig_s3_q;
	logic trig_lvl_q; // agreed pin level
	logic trig_prev_q;
	logic dig_rise;

	// analog level trigger
	logic [sad_pkg::ADC_W-1:0] ana_prev_q; // last kept sample
	logic ana_have_q; // a previous sample exists
	logic [sad_pkg::ADC_W-1:0] ana_cur;
	logic ana_rise;

	// sample memory ports
	sad_pkg::sad_sample_t wr_sample;
	sad_pkg::sad_sample_t rd_sample;
	logic [AW-1:0] rd_addr;

	// an accepted address phase of a transfer to this slave
	assign addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
	assign start_cmd = wr_pend_q && addr_q == sad_pkg::REG_CTRL &&
		HWDATA_I[sad_pkg::CTRL_START];
	assign abort_cmd = wr_pend_q && addr_q == sad_pkg::REG_CTRL &&
		HWDATA_I[sad_pkg::CTRL_ABORT];

	// address phase capture
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			addr_q <= 8'h00;
			wr_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= addr_phase & HWRITE_I;
			if (addr_phase)
				addr_q <= HADDR_I[7:0];
		end
	end

	// read answer: one wait state, two for sample data
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			wait_q <= 2'h0;
			hready_q <= 1'b1;
			hrdata_q <= 32'h0000_0000;
		end else if (addr_phase && !HWRITE_I) begin
			hready_q <= 1'b0;
			wait_q <= (HADDR_I[7:0] == sad_pkg::REG_RDDATA) ?
				sad_pkg::WAIT_MEM : sad_pkg::WAIT_REG;
		end else if (wait_q == sad_pkg::WAIT_REG) begin
			hready_q <= 1'b1;
			wait_q <= 2'h0;
			hrdata_q <= rd_mux;
		end else if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
		end
	end

	// error response is never used
	always_ff @(posedge CORE_CLK_I) begin
		HRESP_O <= 1'b0;
	end

	// register read decode, unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr_q)
			sad_pkg::REG_CTRL: begin
				rd_mux[sad_pkg::CTRL_TSRC] = ctrl_q.trig_src;
				rd_mux[sad_pkg::CTRL_FILT] = ctrl_q.filter_en;
				rd_mux[sad_pkg::CTRL_TCH] = ctrl_q.trig_ch;
			end
			sad_pkg::REG_STATUS: begin
				rd_mux[sad_pkg::STAT_BUSY] = busy_q;
				rd_mux[sad_pkg::STAT_TRIG] = trig_seen_q;
				rd_mux[sad_pkg::STAT_DONE] = done_q;
				rd_mux[sad_pkg::STAT_ERR] = err_q;
			end
			sad_pkg::REG_DECIM: rd_mux[sad_pkg::DECIM_W-1:0] = decim_q;
			sad_pkg::REG_PRE: rd_mux[CW-1:0] = pre_q;
			sad_pkg::REG_POST: rd_mux[CW-1:0] = post_q;
			sad_pkg::REG_LEN: rd_mux[CW-1:0] = len_q;
			sad_pkg::REG_RANGE: rd_mux[sad_pkg::RANGE_W-1:0] = range_q;
			sad_pkg::REG_OFFSET: begin
				rd_mux[sad_pkg::OFS_W-1:0] = ofs0_q;
				rd_mux[sad_pkg::OFS_CH1_LSB +: sad_pkg::OFS_W] = ofs1_q;
			end
			sad_pkg::REG_TLEVEL: rd_mux[sad_pkg::ADC_W-1:0] = tlevel_q;
			sad_pkg::REG_RDIDX: rd_mux[CW-1:0] = rd_idx_q;
			sad_pkg::REG_RDDATA: begin
				// beyond the programmed length nothing is handed over
				if (rd_idx_q < len_q)
					rd_mux[15:0] = rd_sample;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// configuration writes
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			ctrl_q <= '0;
			decim_q <= sad_pkg::DECIM_RST;
			pre_q <= sad_pkg::PRE_RST;
			post_q <= sad_pkg::POST_RST;
			len_q <= sad_pkg::LEN_RST;
			range_q <= sad_pkg::RANGE_RST;
			ofs0_q <= sad_pkg::OFS_RST;
			ofs1_q <= sad_pkg::OFS_RST;
			tlevel_q <= sad_pkg::TLEVEL_RST;
		end else if (wr_pend_q) begin
			unique case (addr_q)
				sad_pkg::REG_CTRL: begin
					ctrl_q.trig_src <= HWDATA_I[sad_pkg::CTRL_TSRC];
					ctrl_q.filter_en <= HWDATA_I[sad_pkg::CTRL_FILT];
					ctrl_q.trig_ch <= HWDATA_I[sad_pkg::CTRL_TCH];
				end
				sad_pkg::REG_DECIM: begin
					// zero is no whole divisor, keep the old factor
					if (HWDATA_I[sad_pkg::DECIM_W-1:0] != 16'h0000)
						decim_q <= HWDATA_I[sad_pkg::DECIM_W-1:0];
				end
				sad_pkg::REG_PRE: begin
					// frozen from the start edge on, busy_q lags a cycle
					if (!running)
						pre_q <= HWDATA_I[CW-1:0];
				end
				sad_pkg::REG_POST: begin
					if (!running)
						post_q <= HWDATA_I[CW-1:0];
				end
				sad_pkg::REG_LEN: len_q <= HWDATA_I[CW-1:0];
				sad_pkg::REG_RANGE: begin
					// codes past the last range are ignored
					if (HWDATA_I[31:0] < 32'(sad_pkg::RANGE_COUNT))
						range_q <= HWDATA_I[sad_pkg::RANGE_W-1:0];
				end
				sad_pkg::REG_OFFSET: begin
					ofs0_q <= HWDATA_I[sad_pkg::OFS_W-1:0];
					ofs1_q <= HWDATA_I[sad_pkg::OFS_CH1_LSB +: sad_pkg::OFS_W];
				end
				sad_pkg::REG_TLEVEL: tlevel_q <= HWDATA_I[sad_pkg::ADC_W-1:0];
				default: ;
			endcase
		end
	end

	// host read index: set by write, advances on each data read below the programmed length
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I)
			rd_idx_q <= '0;
		else if (wr_pend_q && addr_q == sad_pkg::REG_RDIDX)
			rd_idx_q <= HWDATA_I[CW-1:0];
		else if (wait_q == sad_pkg::WAIT_REG &&
			addr_q == sad_pkg::REG_RDDATA && rd_idx_q < len_q)
			rd_idx_q <= rd_idx_q + 1'b1;
	end

	// hardware-facing settings; position goes out only as the two offset dac codes
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			RANGE_SEL_O <= sad_pkg::RANGE_RST;
			FILTER_EN_O <= 1'b0;
			OFFSET_CH0_O <= sad_pkg::OFS_RST;
			OFFSET_CH1_O <= sad_pkg::OFS_RST;
		end else begin
			RANGE_SEL_O <= range_q;
			FILTER_EN_O <= ctrl_q.filter_en;
			OFFSET_CH0_O <= ofs0_q;
			OFFSET_CH1_O <= ofs1_q;
		end
	end

	// digital trigger pin: three flops, level changes when two agree
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
			trig_lvl_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			trig_s1_q <= TRIG_I;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
			if (trig_s2_q == trig_s3_q)
				trig_lvl_q <= trig_s3_q;
			trig_prev_q <= trig_lvl_q;
		end
	end
	assign dig_rise = trig_lvl_q & ~trig_prev_q;

	// analog trigger: rising crossing of the level on kept samples
	assign ana_cur = ctrl_q.trig_ch ? ADC_CH1_I : ADC_CH0_I;
	assign ana_rise = keep & ana_have_q & (ana_prev_q < tlevel_q) &
		(ana_cur >= tlevel_q);
	always_ff @(posedge CORE_CLK_I) begin
		// a start that is ignored while running leaves the history alone
		if (SRST_I || (start_cmd && !running)) begin
			ana_prev_q <= 8'h00;
			ana_have_q <= 1'b0;
		end else if (keep) begin
			ana_prev_q <= ana_cur;
			ana_have_q <= 1'b1;
		end
	end
	assign trig_evt = ctrl_q.trig_src ? ana_rise : dig_rise;

	// decimator: keep the sample whose phase is zero
	assign running = state_q == sad_pkg::ST_PRE ||
		state_q == sad_pkg::ST_ARMED || state_q == sad_pkg::ST_POST;
	assign keep = running & ADC_VALID_I & (dec_cnt_q == '0);
	always_ff @(posedge CORE_CLK_I) begin
		// only a start while idle or done restarts the phase
		if (SRST_I || (start_cmd && !running))
			dec_cnt_q <= '0;
		else if (running && ADC_VALID_I)
			dec_cnt_q <= (dec_cnt_q >= decim_q - 1'b1) ? '0 :
				dec_cnt_q + 1'b1;
	end

	// record size check, raw codes are stored whatever the offset
	assign total = (CW+1)'(pre_q) + (CW+1)'(post_q);
	assign split_ok = total <= DEPTH_C;
	assign wr_sample.ch0 = ADC_CH0_I;
	assign wr_sample.ch1 = ADC_CH1_I;

	// acquisition sequence
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			state_q <= sad_pkg::ST_IDLE;
			wr_ptr_q <= '0;
			stored_q <= '0;
			post_cnt_q <= '0;
			base_q <= '0;
			trig_seen_q <= 1'b0;
			err_q <= 1'b0;
		end else if (abort_cmd) begin
			state_q <= sad_pkg::ST_IDLE;
		end else if (start_cmd && !running) begin
			err_q <= ~split_ok;
			trig_seen_q <= 1'b0;
			wr_ptr_q <= '0;
			stored_q <= '0;
			post_cnt_q <= '0;
			if (split_ok)
				state_q <= sad_pkg::ST_PRE;
		end else begin
			if (keep)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			unique case (state_q)
				sad_pkg::ST_IDLE, sad_pkg::ST_DONE: ;
				sad_pkg::ST_PRE: begin
					// arm only once the pretrigger part is filled
					if (stored_q >= pre_q)
						state_q <= sad_pkg::ST_ARMED;
					else if (keep)
						stored_q <= stored_q + 1'b1;
				end
				sad_pkg::ST_ARMED: begin
					if (trig_evt) begin
						trig_seen_q <= 1'b1;
						if (post_q == '0) begin
							state_q <= sad_pkg::ST_DONE;
							base_q <= ring_add(wr_ptr_q + AW'(keep),
								(CW+1)'(DEPTH) - total);
						end else begin
							state_q <= sad_pkg::ST_POST;
						end
					end
				end
				sad_pkg::ST_POST: begin
					if (keep) begin
						post_cnt_q <= post_cnt_q + 1'b1;
						if (post_cnt_q + 1'b1 == post_q) begin
							state_q <= sad_pkg::ST_DONE;
							base_q <= ring_add(wr_ptr_q + 1'b1,
								(CW+1)'(DEPTH) - total);
						end
					end
				end
			endcase
		end
	end

	// status outputs
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			busy_q <= running;
			done_q <= state_q == sad_pkg::ST_DONE;
		end
	end
	assign ACQ_BUSY_O = busy_q;
	assign ACQ_DONE_O = done_q;
	assign HRDATA_O = hrdata_q;
	assign HREADYOUT_O = hready_q;

	// host reads walk the record from its oldest sample
	assign rd_addr = ring_add(base_q, (CW+1)'(rd_idx_q));

	sad_acq_mem #(
		.WIDTH(2 * sad_pkg::ADC_W),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.clk_i(CORE_CLK_I),
		.wr_en_i(keep),
		.wr_addr_i(wr_ptr_q),
		.wr_data_i(wr_sample),
		.rd_addr_i(rd_addr),
		.rd_data_o(rd_sample)
	);

endmodule

/* File: tb/sad_adc_model.sv */
// adc source model: ramp of sample codes, one pair every other clock
`timescale 1ns/1ps
module sad_adc_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	output logic valid_o,
	output sad_pkg::sad_sample_t smp_o
);
	logic [7:0] cnt_q; // index of the next conversion
	logic ph_q; // alternate-cycle phase

	// 100 MS/s conversions on the 200 MHz core clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 8'h00;
			ph_q <= 1'b0;
			valid_o <= 1'b0;
			smp_o <= 16'h0000;
		end else if (!en_i) begin
			// idle: ramp restarts, lines keep toggling
			cnt_q <= 8'h00;
			ph_q <= 1'b0;
			valid_o <= 1'b0;
			smp_o <= ~smp_o;
		end else begin
			ph_q <= !ph_q;
			valid_o <= !ph_q;
			if (!ph_q) begin
				// channel 1 carries the inverse code
				smp_o <= {~cnt_q, cnt_q};
				cnt_q <= cnt_q + 8'h01;
			end else begin
				// hold time over: lines no longer valid
				smp_o <= ~smp_o;
			end
		end
	end
endmodule

/* File: tb/sad_top_asserts.sv */
// assertion checker on the acquisition block ports
`timescale 1ns/1ps
module sad_top_asserts (
	input wire logic CORE_CLK_I,
	input wire logic SRST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic HWRITE_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HREADY_I,
	input wire logic HREADYOUT_O,
	input wire logic HRESP_O,
	input wire logic [sad_pkg::RANGE_W-1:0] RANGE_SEL_O,
	input wire logic FILTER_EN_O,
	input wire logic [sad_pkg::OFS_W-1:0] OFFSET_CH0_O,
	input wire logic [sad_pkg::OFS_W-1:0] OFFSET_CH1_O,
	input wire logic ACQ_BUSY_O,
	input wire logic ACQ_DONE_O
);
	logic dp_q; // write data phase pending
	logic [7:0] da_q; // byte offset of that write
	logic wr_ctrl; // control write in its data phase
	logic wr_ofs; // offset write in its data phase

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (SRST_I);

	// follow each write into its data phase
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			dp_q <= 1'b0;
			da_q <= 8'h00;
		end else if (HREADY_I) begin
			dp_q <= HSEL_I && HTRANS_I[1] && HWRITE_I;
			da_q <= HADDR_I[7:0];
		end
	end
	assign wr_ctrl = dp_q && (da_q == sad_pkg::REG_CTRL);
	assign wr_ofs = dp_q && (da_q == sad_pkg::REG_OFFSET);

	AST_RANGE: assert property (RANGE_SEL_O < 4'hA)
		else $error("range code outside the ten ranges");
	AST_OFS0: assert property ($changed(OFFSET_CH0_O) |->
		$past(wr_ofs) || $past(wr_ofs, 2))
		else $error("channel 0 offset moved without a write");
	AST_OFS1: assert property ($changed(OFFSET_CH1_O) |->
		$past(wr_ofs) || $past(wr_ofs, 2))
		else $error("channel 1 offset moved without a write");
	AST_FILT: assert property ($changed(FILTER_EN_O) |->
		$past(wr_ctrl) || $past(wr_ctrl, 2))
		else $error("filter switched without a control write");
	AST_DONE_IDLE: assert property (ACQ_DONE_O |-> !ACQ_BUSY_O)
		else $error("done while still acquiring");
	AST_BUSY_START: assert property ($rose(ACQ_BUSY_O) |->
		$past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
		else $error("acquisition began without a start");
	AST_DONE_CLR: assert property ($fell(ACQ_DONE_O) |->
		$past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
		else $error("done dropped without a control write");
	AST_WAIT: assert property ($fell(HREADYOUT_O) |->
		$past(HSEL_I && HTRANS_I[1] && !HWRITE_I))
		else $error("wait state not caused by a read");
	AST_WAIT_LEN: assert property (!HREADYOUT_O |-> ##[1:2] HREADYOUT_O)
		else $error("read wait too long");
	AST_RESP: assert property (!HRESP_O)
		else $error("response not okay");
endmodule

bind sad_top sad_top_asserts chk_u (.CORE_CLK_I(CORE_CLK_I),
	.SRST_I(SRST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
	.HWRITE_I(HWRITE_I), .HTRANS_I(HTRANS_I), .HREADY_I(HREADY_I),
	.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
	.RANGE_SEL_O(RANGE_SEL_O), .FILTER_EN_O(FILTER_EN_O),
	.OFFSET_CH0_O(OFFSET_CH0_O), .OFFSET_CH1_O(OFFSET_CH1_O),
	.ACQ_BUSY_O(ACQ_BUSY_O), .ACQ_DONE_O(ACQ_DONE_O));

/* File: tb/sad_top_test.sv */
// self-checking bench of the scope acquisition block
`timescale 1ns/1ps
module sad_top_test;
	logic clk; // 200 MHz core clock
	logic srst; // synchronous reset
	logic hsel, hwrite, trig, adc_en, adc_v, hrdy, hresp, filt, busy, done;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, x;
	logic [3:0] rsel; // range code pins
	logic [11:0] ofs0, ofs1; // offset dac codes
	sad_pkg::sad_sample_t adc_s; // sample pair from the model
	int n_errors, checks_done;

	sad_top dut_u (.CORE_CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel),
		.HADDR_I(haddr), .HWRITE_I(hwrite), .HTRANS_I(htrans),
		.HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
		.HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
		.ADC_VALID_I(adc_v), .ADC_CH0_I(adc_s.ch0),
		.ADC_CH1_I(adc_s.ch1), .TRIG_I(trig), .RANGE_SEL_O(rsel),
		.FILTER_EN_O(filt), .OFFSET_CH0_O(ofs0), .OFFSET_CH1_O(ofs1),
		.ACQ_BUSY_O(busy), .ACQ_DONE_O(done));
	sad_adc_model adc_u (.clk_i(clk), .rst_i(srst), .en_i(adc_en),
		.valid_o(adc_v), .smp_o(adc_s));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// verdict and end of run
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// compare one value
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	// one single ahb transfer, address then data phase
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		r = hrdata;
	endtask

	// read a register and compare it
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk($sformatf("reg %h", a), e, r);
	endtask

	// wait for the record to complete
	task automatic wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		chk("done pin", 32'h0000_0001, {31'h0, done});
		chk("busy pin", 32'h0000_0000, {31'h0, busy});
	endtask

	// reset values and an unmapped place
	task automatic t_reset_vals;
		rdchk(sad_pkg::REG_DECIM, 32'h0000_0001);
		rdchk(sad_pkg::REG_PRE, 32'h0000_0000);
		rdchk(sad_pkg::REG_POST, 32'h0000_4000);
		rdchk(sad_pkg::REG_LEN, 32'h0000_4000);
		rdchk(sad_pkg::REG_RANGE, 32'h0000_0009);
		rdchk(sad_pkg::REG_OFFSET, 32'h0800_0800);
		rdchk(sad_pkg::REG_STATUS, 32'h0000_0000);
		rdchk(sad_pkg::REG_TLEVEL, 32'h0000_0080);
		rdchk(sad_pkg::REG_CTRL, 32'h0000_0000);
		rdchk(8'h2C, 32'h0000_0000);
	endtask

	// range, offset, filter and decimation settings
	task automatic t_settings;
		for (int i = 0; i < 10; i++) begin
			ahb(1'b1, sad_pkg::REG_RANGE, 32'(i), x);
			rdchk(sad_pkg::REG_RANGE, 32'(i));
			chk("range pin", 32'(i), {28'h0, rsel});
		end
		ahb(1'b1, sad_pkg::REG_RANGE, 32'h0000_000A, x);
		chk("range kept", 32'h0000_0009, {28'h0, rsel});
		ahb(1'b1, sad_pkg::REG_DECIM, 32'h0000_0000, x);
		rdchk(sad_pkg::REG_DECIM, 32'h0000_0001);
		ahb(1'b1, sad_pkg::REG_OFFSET, 32'h0ABC_0123, x);
		rdchk(sad_pkg::REG_OFFSET, 32'h0ABC_0123);
		chk("offset 0", 32'h0000_0123, {20'h0, ofs0});
		chk("offset 1", 32'h0000_0ABC, {20'h0, ofs1});
		ahb(1'b1, sad_pkg::REG_CTRL, 32'h0000_0018, x);
		rdchk(sad_pkg::REG_CTRL, 32'h0000_0018);
		chk("filter pin", 32'h0000_0001, {31'h0, filt});
	endtask

	// decimate by 4, analog level trigger, 2 pre plus 3 post sample record, short readout
	task automatic t_analog_acq;
		logic [7:0] v;
		ahb(1'b1, sad_pkg::REG_DECIM, 32'h0000_0004, x);
		ahb(1'b1, sad_pkg::REG_PRE, 32'h0000_0002, x);
		ahb(1'b1, sad_pkg::REG_POST, 32'h0000_0003, x);
		ahb(1'b1, sad_pkg::REG_LEN, 32'h0000_0004, x);
		ahb(1'b1, sad_pkg::REG_TLEVEL, 32'h0000_0014, x);
		ahb(1'b1, sad_pkg::REG_CTRL, 32'h0000_0005, x);
		adc_en <= 1'b1;
		wait_done();
		chk("filter off", 32'h0000_0000, {31'h0, filt});
		rdchk(sad_pkg::REG_STATUS, 32'h0000_0006);
		ahb(1'b1, sad_pkg::REG_RDIDX, 32'h0000_0000, x);
		for (int i = 0; i < 4; i++) begin
			v = 8'(16 + 4 * i);
			rdchk(sad_pkg::REG_RDDATA, {16'h0, ~v, v});
		end
		rdchk(sad_pkg::REG_RDDATA, 32'h0000_0000);
	endtask

	// digital pin trigger with no pretrigger samples
	task automatic t_pin_trig;
		ahb(1'b1, sad_pkg::REG_DECIM, 32'h0000_0001, x);
		ahb(1'b1, sad_pkg::REG_PRE, 32'h0000_0000, x);
		ahb(1'b1, sad_pkg::REG_POST, 32'h0000_0002, x);
		ahb(1'b1, sad_pkg::REG_CTRL, 32'h0000_0001, x);
		rdchk(sad_pkg::REG_STATUS, 32'h0000_0001);
		trig <= 1'b1;
		wait_done();
		rdchk(sad_pkg::REG_STATUS, 32'h0000_0006);
		trig <= 1'b0;
	endtask

	// pre/post split against memory size, write lock, abort
	task automatic t_split;
		logic [31:0] r;
		ahb(1'b1, sad_pkg::REG_PRE, 32'h0000_0001, x);
		ahb(1'b1, sad_pkg::REG_POST, 32'h0000_4000, x);
		ahb(1'b1, sad_pkg::REG_CTRL, 32'h0000_0001, x);
		ahb(1'b0, sad_pkg::REG_STATUS, 32'h0000_0000, r);
		chk("err bit", 32'h0000_0001, {31'h0, r[3]});
		chk("no start", 32'h0000_0000, {31'h0, r[0]});
		ahb(1'b1, sad_pkg::REG_PRE, 32'h0000_2000, x);
		ahb(1'b1, sad_pkg::REG_POST, 32'h0000_2000, x);
		ahb(1'b1, sad_pkg::REG_CTRL, 32'h0000_0001, x);
		ahb(1'b0, sad_pkg::REG_STATUS, 32'h0000_0000, r);
		chk("busy bit", 32'h0000_0001, {31'h0, r[0]});
		ahb(1'b1, sad_pkg::REG_PRE, 32'h0000_0005, x);
		rdchk(sad_pkg::REG_PRE, 32'h0000_2000);
		ahb(1'b1, sad_pkg::REG_CTRL, 32'h0000_0002, x);
		ahb(1'b0, sad_pkg::REG_STATUS, 32'h0000_0000, r);
		chk("aborted", 32'h0000_0000, {31'h0, r[0]});
	endtask

	// main sequence
	initial begin
		srst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		htrans = 2'h0;
		hwdata = 32'h0000_0000;
		trig = 1'b0;
		adc_en = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		t_reset_vals();
		t_settings();
		t_analog_acq();
		t_pin_trig();
		t_split();
		end_sim();
	end

	// watchdog against a hang
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		end_sim();
	end
endmodule
